// ### verif/psd_vco_model.sv
// Behavioural voltage controlled oscillator feeding both band input pins.
`timescale 1ns/10ps

module psd_vco_model (
  // Clock and control from the bench.
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic use_high_i,
  input wire logic [7:0] half_i,
  // Pull-down requests from the block.
  input wire logic high_pd_i,
  input wire logic low_pd_i,
  // Oscillator pins.
  output logic high_o,
  output logic low_o
);
  logic osc = 1'b0;
  logic flip = 1'b0;
  logic [7:0] cnt = 8'h00;

  // ---------------------------------------------------------------------------
  // Oscillator
  // ---------------------------------------------------------------------------
  // Toggles every half_i cycles off the falling edge, so a period is 2*half_i.
  always @(negedge clk_i) begin
    flip <= ~flip;
    if (!run_i) begin
      osc <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= half_i) begin
      osc <= ~osc;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // A pulled-down pin reads low; an unused open pin wanders, so it toggles.
  assign high_o = high_pd_i ? 1'b0 : (use_high_i ? osc : flip);
  assign low_o = low_pd_i ? 1'b0 : (use_high_i ? flip : osc);
endmodule // psd_vco_model

// ### verif/tb_psd_pll_ctrl.sv
// Self-checking testbench for the PLL synthesizer divider control block.
`timescale 1ns/10ps

module tb_psd_pll_ctrl;
  import psd_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic tick = 1'b1;
  logic run = 1'b0;
  logic use_high = 1'b0;
  logic [7:0] half = 8'h02;
  logic [7:0] rdata;
  logic hi_in, lo_in, hi_pd, lo_pd, err, err_oe;
  int n_fail = 0;
  int compares = 0;

  // 10 MHz system clock.
  always #50 mclk = ~mclk;

  psd_pll_ctrl uut (
    .MCLK_I(mclk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr_s),
    .SFR_RD_I(rd_s), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
    .HIGH_BAND_OSC_INPUT_I(hi_in), .LOW_BAND_OSC_INPUT_I(lo_in),
    .FOSC_TICK_I(tick), .HIGH_BAND_PULLDOWN_O(hi_pd),
    .LOW_BAND_PULLDOWN_O(lo_pd), .PHASE_ERROR_OUTPUT_O(err),
    .PHASE_ERROR_OUTPUT_OE_O(err_oe)
  );

  psd_vco_model vco (
    .clk_i(mclk), .run_i(run), .use_high_i(use_high), .half_i(half),
    .high_pd_i(hi_pd), .low_pd_i(lo_pd), .high_o(hi_in), .low_o(lo_in)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Strobes are one cycle wide and change only at the falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge mclk);
    wr_s = 1'b0;
  endtask

  // Read data is registered at the read edge and then holds.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr = a;
    rd_s = 1'b1;
    @(negedge mclk);
    rd_s = 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic finish_test;
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    chk_bit("high pulldown", 1'b1, hi_pd);
    chk_bit("low pulldown", 1'b1, lo_pd);
    chk_bit("error enable", 1'b0, err_oe);
    rd(8'hf1, d);
    chk_byte("mode after reset", 8'h00, d);
  endtask

  // Walk every input mode with the loop stopped, then try reserved bits.
  task automatic t_modes;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      wr(8'hf1, {4'h1, 2'b00, m[1:0]});
      idle(3);
      chk_bit("high pulldown", m != 1, hi_pd);
      chk_bit("low pulldown", m < 2, lo_pd);
      rd(8'hf1, d);
      chk_byte("mode readback", {4'h1, 2'b00, m[1:0]}, d);
    end
    wr(8'hf1, 8'h1c);
    rd(8'hf1, d);
    chk_byte("reserved mode bits", 8'h10, d);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    wr(8'hf2, 8'ha5);
    wr(8'hf3, 8'h3c);
    rd(8'hf2, d);
    chk_byte("division high", 8'ha5, d);
    rd(8'hf3, d);
    chk_byte("division low", 8'h3c, d);
    // A read straight after a write must return the new byte.
    @(negedge mclk);
    addr = 8'hf2;
    wdata = 8'h5a;
    wr_s = 1'b1;
    @(negedge mclk);
    wr_s = 1'b0;
    rd_s = 1'b1;
    @(negedge mclk);
    rd_s = 1'b0;
    @(negedge mclk);
    chk_byte("back to back read", 8'h5a, rdata);
    rd(8'h55, d);
    chk_byte("unmapped read", 8'h00, d);
    wr(8'hf4, 8'hff);
    rd(8'hf4, d);
    chk_byte("judge after write", 8'h00, d);
  endtask

  // Run the loop on the 50 kHz code, a 144-cycle reference at this clock, let it settle, then stop and judge.
  task automatic t_run(input psd_mode_type md, input logic [15:0] nval,
                       input logic exp_out);
    logic [7:0] d;
    int k;
    wr(8'hf1, 8'h10);
    use_high = (md == MODE_VHF);
    run = 1'b1;
    wr(8'hf2, nval[15:8]);
    wr(8'hf3, nval[7:0]);
    wr(8'hf1, {4'he, 2'b00, md});
    for (k = 0; k < 3000 && !(err_oe === 1'b1 && err === exp_out); k++)
      @(negedge mclk);
    chk_bit("error enable", 1'b1, err_oe);
    chk_bit("error level", exp_out, err);
    idle(300);
    rd(8'hf4, d);
    idle(200);
    wr(8'hf1, {4'h1, 2'b00, md});
    idle(4);
    chk_bit("error enable stopped", 1'b0, err_oe);
    rd(8'hf4, d);
    chk_byte("judge set", exp_out ? 8'h01 : 8'h02, d);
    rd(8'hf4, d);
    chk_byte("judge cleared", 8'h00, d);
    run = 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    idle(8);
    rst_n = 1'b1;
    t_reset();
    t_modes();
    t_regs();
    // Period 4 cycles: MF divides by 16, swallow modes by 256 or more.
    t_run(MODE_MF, 16'h0108, 1'b1);
    t_run(MODE_HF, 16'h0100, 1'b0);
    t_run(MODE_VHF, 16'h0108, 1'b0);
    finish_test();
  end

  // The run needs under 8000 cycles; 20000 means something hung.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
endmodule // tb_psd_pll_ctrl

// ### verilog/psd_defs.svh
// Constants for the PLL synthesizer divider control block.
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define PSD_MODE_ADDR 8'hf1
`define PSD_DATA_HI_ADDR 8'hf2
`define PSD_DATA_LO_ADDR 8'hf3
`define PSD_JUDGE_ADDR 8'hf4

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PSD_REF_MSB 7
`define PSD_REF_LSB 4
`define PSD_MD_MSB 1
`define PSD_MD_LSB 0
`define PSD_MODE_RESET 8'h00
`define PSD_DATA_RESET 16'h0000
`define PSD_MODE_WMASK 8'hf3

// ----------------------------------------------------------------------------
// Divider and reference constants
// ----------------------------------------------------------------------------
`define PSD_PRESCALE_LO 5'h10
`define PSD_PRESCALE_HI 5'h11
`define PSD_REF_STOP 4'h1
`define PSD_REF_FIRST 4'h2
`define PSD_REF_LAST 4'he
// Reference divisors counted in 7.2 MHz main clock ticks.
`define PSD_DIV_1K 13'h1c20
`define PSD_DIV_1K25 13'h1680
`define PSD_DIV_2K5 13'h0b40
`define PSD_DIV_3K 13'h0960
`define PSD_DIV_5K 13'h05a0
`define PSD_DIV_6K25 13'h0480
`define PSD_DIV_9K 13'h0320
`define PSD_DIV_10K 13'h02d0
`define PSD_DIV_12K5 13'h0240
`define PSD_DIV_18K 13'h0190
`define PSD_DIV_20K 13'h0168
`define PSD_DIV_25K 13'h0120
`define PSD_DIV_50K 13'h0090

`endif

// ### verilog/psd_pkg.sv
// Types shared by the PLL synthesizer divider control block.
package psd_pkg;

  // Input selection and division system.
  typedef enum logic [1:0] {
    MODE_DISABLE = 2'b00,
    MODE_VHF = 2'b01,
    MODE_HF = 2'b10,
    MODE_MF = 2'b11
  } psd_mode_type;

  // Phase comparator state.
  typedef enum logic [2:0] {
    PFD_IDLE = 3'b001,
    PFD_REF_LEAD = 3'b010,
    PFD_DIV_LEAD = 3'b100
  } psd_pfd_type;

endpackage

// ### verilog/psd_pll_ctrl.sv
// PLL synthesizer control: input select, divider, reference, comparator.
`timescale 1ns/10ps
`include "psd_defs.svh"

module psd_pll_ctrl (
  // Clock and reset.
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // Special function register port.
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // Oscillator inputs and main clock tick.
  input wire logic HIGH_BAND_OSC_INPUT_I,
  input wire logic LOW_BAND_OSC_INPUT_I,
  input wire logic FOSC_TICK_I,
  // Pin control and error output.
  output logic HIGH_BAND_PULLDOWN_O,
  output logic LOW_BAND_PULLDOWN_O,
  output logic PHASE_ERROR_OUTPUT_O,
  output logic PHASE_ERROR_OUTPUT_OE_O
);
  import psd_pkg::*;

  // --------------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------------
  logic [7:0] pll_mode_select;
  logic [15:0] data_reg;
  logic [15:0] data_buf;
  logic unlock_judge_bit1;
  logic unlock_judge_bit0;
  logic [3:0] swallow_down_counter;
  logic [11:0] programmable_down_counter;
  logic [4:0] pre_cnt;
  logic osc_q;
  logic [12:0] ref_cnt;
  logic ref_pulse;
  logic seen_low;
  logic seen_high;
  psd_pfd_type pfd_state;
  psd_pfd_type next_pfd_state;

  wire [3:0] ref_freq_select = pll_mode_select[`PSD_REF_MSB:`PSD_REF_LSB];
  wire psd_mode_type input_division_mode =
    psd_mode_type'(pll_mode_select[`PSD_MD_MSB:`PSD_MD_LSB]);
  wire wr_mode = SFR_WR_I && (SFR_ADDR_I == `PSD_MODE_ADDR);
  wire wr_hi = SFR_WR_I && (SFR_ADDR_I == `PSD_DATA_HI_ADDR);
  wire wr_lo = SFR_WR_I && (SFR_ADDR_I == `PSD_DATA_LO_ADDR);
  wire rd_judge = SFR_RD_I && (SFR_ADDR_I == `PSD_JUDGE_ADDR);

  // Read data; unmapped addresses read as zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (SFR_ADDR_I)
      `PSD_MODE_ADDR: rd_mux = pll_mode_select;
      `PSD_DATA_HI_ADDR: rd_mux = data_reg[15:8];
      `PSD_DATA_LO_ADDR: rd_mux = data_reg[7:0];
      `PSD_JUDGE_ADDR: rd_mux = {6'h00, unlock_judge_bit1, unlock_judge_bit0};
      default: rd_mux = 8'h00;
    endcase
  end

  // Reserved mode bits are held at zero, their inactive value.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pll_mode_select <= `PSD_MODE_RESET;
      data_reg <= `PSD_DATA_RESET;
      SFR_RDATA_O <= 8'h00;
    end else begin
      if (wr_mode)
        pll_mode_select <= SFR_WDATA_I & `PSD_MODE_WMASK;
      if (wr_hi)
        data_reg[15:8] <= SFR_WDATA_I;
      if (wr_lo)
        data_reg[7:0] <= SFR_WDATA_I;
      if (SFR_RD_I)
        SFR_RDATA_O <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // Input selection
  // --------------------------------------------------------------------------
  wire div_on = (input_division_mode != MODE_DISABLE);
  wire swallow_mode = (input_division_mode == MODE_VHF) ||
                      (input_division_mode == MODE_HF);
  wire osc_sel = (input_division_mode == MODE_VHF) ?
                 HIGH_BAND_OSC_INPUT_I : LOW_BAND_OSC_INPUT_I;
  wire osc_rise = div_on && osc_sel && !osc_q;

  // The unused pin is pulled down so a floating VCO line cannot toggle.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      HIGH_BAND_PULLDOWN_O <= 1'b1;
      LOW_BAND_PULLDOWN_O <= 1'b1;
      osc_q <= 1'b0;
    end else begin
      HIGH_BAND_PULLDOWN_O <= (input_division_mode != MODE_VHF);
      LOW_BAND_PULLDOWN_O <= (input_division_mode != MODE_HF) &&
                             (input_division_mode != MODE_MF);
      osc_q <= div_on && osc_sel;
    end
  end

  // --------------------------------------------------------------------------
  // Programmable divider
  // --------------------------------------------------------------------------
  // While the swallow counter is non-zero the prescaler divides by 17, so
  // the total count is 16 times the upper field plus the lower field.
  wire [4:0] pre_mod = (swallow_down_counter != 4'h0) ?
                       `PSD_PRESCALE_HI : `PSD_PRESCALE_LO;
  wire pre_wrap = swallow_mode && osc_rise &&
                  (pre_cnt == pre_mod - 5'h01);
  wire pc_step = swallow_mode ? pre_wrap : osc_rise;
  wire pc_end = pc_step && (programmable_down_counter <= 12'h001);
  wire fn_pulse = pc_end;

  // Counters load only from the buffer, which reloads from the register.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      data_buf <= `PSD_DATA_RESET;
      programmable_down_counter <= 12'h000;
      swallow_down_counter <= 4'h0;
      pre_cnt <= 5'h00;
    end else if (!div_on || pc_end) begin
      data_buf <= data_reg;
      programmable_down_counter <= data_buf[15:4];
      swallow_down_counter <= swallow_mode ? data_buf[3:0] : 4'h0;
      pre_cnt <= 5'h00;
    end else begin
      if (!swallow_mode)
        swallow_down_counter <= 4'h0;
      else if (pre_wrap && swallow_down_counter != 4'h0)
        swallow_down_counter <= swallow_down_counter - 4'h1;
      if (!swallow_mode)
        pre_cnt <= 5'h00;
      else if (osc_rise)
        pre_cnt <= pre_wrap ? 5'h00 : pre_cnt + 5'h01;
      if (pc_step)
        programmable_down_counter <= programmable_down_counter - 12'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Reference generator
  // --------------------------------------------------------------------------
  // Maps the reference code to a divisor of the 7.2 MHz tick.
  function automatic logic [12:0] ref_divisor(input logic [3:0] code);
    case (code)
      4'h2: ref_divisor = `PSD_DIV_1K;
      4'h3: ref_divisor = `PSD_DIV_1K25;
      4'h4: ref_divisor = `PSD_DIV_2K5;
      4'h5: ref_divisor = `PSD_DIV_3K;
      4'h6: ref_divisor = `PSD_DIV_5K;
      4'h7: ref_divisor = `PSD_DIV_6K25;
      4'h8: ref_divisor = `PSD_DIV_9K;
      4'h9: ref_divisor = `PSD_DIV_10K;
      4'ha: ref_divisor = `PSD_DIV_12K5;
      4'hb: ref_divisor = `PSD_DIV_18K;
      4'hc: ref_divisor = `PSD_DIV_20K;
      4'hd: ref_divisor = `PSD_DIV_25K;
      default: ref_divisor = `PSD_DIV_50K;
    endcase
  endfunction

  // Stop, zero and the reserved code all hold the reference still.
  wire ref_on = (ref_freq_select >= `PSD_REF_FIRST) &&
                (ref_freq_select <= `PSD_REF_LAST);
  wire ref_wrap = FOSC_TICK_I &&
                  (ref_cnt >= ref_divisor(ref_freq_select) - 13'h0001);

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ref_cnt <= 13'h0000;
      ref_pulse <= 1'b0;
    end else if (!ref_on) begin
      ref_cnt <= 13'h0000;
      ref_pulse <= 1'b0;
    end else begin
      ref_pulse <= ref_wrap;
      if (FOSC_TICK_I)
        ref_cnt <= ref_wrap ? 13'h0000 : ref_cnt + 13'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Phase comparator, charge pump and unlock detector
  // --------------------------------------------------------------------------
  wire pll_run = ref_on && div_on;

  // Whichever edge arrives first opens the error window; the other closes it.
  always_comb begin
    next_pfd_state = pfd_state;
    if (!pll_run)
      next_pfd_state = PFD_IDLE;
    else begin
      case (pfd_state)
        PFD_IDLE: begin
          if (ref_pulse && !fn_pulse)
            next_pfd_state = PFD_REF_LEAD;
          else if (fn_pulse && !ref_pulse)
            next_pfd_state = PFD_DIV_LEAD;
        end
        PFD_REF_LEAD: begin
          if (fn_pulse && !ref_pulse)
            next_pfd_state = PFD_IDLE;
        end
        PFD_DIV_LEAD: begin
          if (ref_pulse && !fn_pulse)
            next_pfd_state = PFD_IDLE;
        end
        default: next_pfd_state = PFD_IDLE;
      endcase
    end
  end

  wire lead_ref = (pfd_state == PFD_REF_LEAD);
  wire lead_div = (pfd_state == PFD_DIV_LEAD);

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pfd_state <= PFD_IDLE;
      PHASE_ERROR_OUTPUT_O <= 1'b0;
      PHASE_ERROR_OUTPUT_OE_O <= 1'b0;
    end else begin
      pfd_state <= next_pfd_state;
      PHASE_ERROR_OUTPUT_O <= (next_pfd_state == PFD_DIV_LEAD);
      PHASE_ERROR_OUTPUT_OE_O <= (next_pfd_state != PFD_IDLE);
    end
  end

  // Errors seen during one reference period are judged at its end; a
  // judge read in the same cycle as a new judgement loses to the set.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seen_low <= 1'b0;
      seen_high <= 1'b0;
      unlock_judge_bit1 <= 1'b0;
      unlock_judge_bit0 <= 1'b0;
    end else begin
      seen_low <= ref_pulse ? 1'b0 : (seen_low || lead_ref);
      seen_high <= ref_pulse ? 1'b0 : (seen_high || lead_div);
      if (ref_pulse && (seen_low || lead_ref))
        unlock_judge_bit1 <= 1'b1;
      else if (rd_judge)
        unlock_judge_bit1 <= 1'b0;
      if (ref_pulse && (seen_high || lead_div))
        unlock_judge_bit0 <= 1'b1;
      else if (rd_judge)
        unlock_judge_bit0 <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_judge_read;
    rd_judge && !ref_pulse;
  endsequence

  sequence s_flags_clear;
    !unlock_judge_bit1 && !unlock_judge_bit0;
  endsequence

  a_disable_pulldown: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    input_division_mode == MODE_DISABLE |=>
      HIGH_BAND_PULLDOWN_O && LOW_BAND_PULLDOWN_O)
    else $error("Disabled mode did not pull down both inputs.");

  a_band_pulldown: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    input_division_mode == MODE_VHF |=>
      LOW_BAND_PULLDOWN_O && !HIGH_BAND_PULLDOWN_O)
    else $error("VHF mode pulled down the wrong input.");

  a_direct_no_swallow: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    input_division_mode == MODE_MF |=>
      swallow_down_counter == 4'h0 && pre_cnt == 5'h00)
    else $error("Direct division used the swallow path.");

  a_prescale_modulus: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    swallow_mode && swallow_down_counter == 4'h0 |-> pre_cnt < 5'h10)
    else $error("Prescaler exceeded divide by 16 with swallow empty.");

  a_reload_buffer: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pc_end && div_on |=>
      programmable_down_counter == $past(data_buf[15:4]) &&
      data_buf == $past(data_reg))
    else $error("Counters did not reload through the buffer.");

  a_error_pin_level: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (lead_ref |-> PHASE_ERROR_OUTPUT_OE_O && !PHASE_ERROR_OUTPUT_O) and
    (lead_div |-> PHASE_ERROR_OUTPUT_OE_O && PHASE_ERROR_OUTPUT_O))
    else $error("Error pin level does not match phase lead.");

  a_error_pin_float: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pfd_state == PFD_IDLE |-> !PHASE_ERROR_OUTPUT_OE_O)
    else $error("Error pin driven while phases agree.");

  a_unlock_set: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    ref_pulse && lead_ref |=> unlock_judge_bit1)
    else $error("Unlock flag not set at reference edge.");

  a_judge_clear: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    s_judge_read |=> s_flags_clear)
    else $error("Judge read did not clear unlock flags.");

  a_ref_stop: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !ref_on ##1 !ref_on |-> !ref_pulse)
    else $error("Reference ran while stopped.");

  a_data_readback: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    wr_hi ##1 (SFR_RD_I && SFR_ADDR_I == `PSD_DATA_HI_ADDR && !wr_hi) |=>
      SFR_RDATA_O == $past(SFR_WDATA_I, 2))
    else $error("Data register high byte did not read back.");

endmodule // psd_pll_ctrl
